// ### src/lie_led_intensity_engine.sv
// Purpose: Three-channel LED intensity engine with fades, colour transitions and pulse streams.
// Assumes: Frames arrive as AXI4-Lite writes; the stored colour sets are loaded by software.
// Notes:   Durations scale with CLK_KHZ, so a small value shortens simulation.
//
// Overview of operation
// - Brightness code decodes to 14 levels; 0 off, D to F full.
// - Brightness code resets to 0 so all outputs stay off.
// - Sixteen stored colour sets of three 8-bit levels each.
// - Colour select copies the chosen set into the working levels.
// - Selected colour set is 0 after reset.
// - Direct-level frame overwrites working levels with arbitrary values.
// - Working level means value divided by 0xFF.
// - Target is decoded brightness times relative channel level.
// - Each channel pulse stream averages to its target level.
// - Enabled fades last the programmed time whatever the endpoints.
// - Fades step with 12-bit resolution over the full range.
// - Fade-up code defaults to 3, fade-down code to 8.
// - Duration codes map to sixteen nominal times 0.28 to 4.56 s.
// - New durations apply from the next brightness change only.
// - Reset restores both fade-duration codes to defaults.
// - Fade durations are counted on the internal clock.
// - Colour transitions use 10-bit resolution per channel.
// - Transition code comes with the colour frame; codes 0-2 listed.
// - Transition codes 3 to 7 listed; code 3 is default.
// - Transition time scales with largest channel change over 255.
`default_nettype none
module lie_led_intensity_engine #(
  parameter int CLK_KHZ = lie_pkg::CLK_KHZ
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // AXI4-Lite write
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic [2:0]  i_s_axi_awprot,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic [2:0]  i_s_axi_arprot,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  // LED pulse streams
  output logic             o_led_channel_a,
  output logic             o_led_channel_b,
  output logic             o_led_channel_c
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [3:0]  brt;
  logic [3:0]  col;
  logic [2:0]  trc;
  logic        fen;
  logic [3:0]  up;
  logic [3:0]  dn;
  logic [7:0]  wl [3];
  logic [23:0] cset [16];
  logic [11:0] cur;
  logic [11:0] tgt;
  logic        fad;
  logic [31:0] facc;
  logic [11:0] fd;
  logic [31:0] fdur;
  logic        tload;
  logic        tbusy;
  logic [9:0]  tmax;
  logic [9:0]  tcnt;
  logic [31:0] tdiv;
  logic [31:0] tcyc;
  logic        tick;
  logic [2:0]  pwm;
  logic        wr_go;
  logic        rd_go;
  logic        cb_we;
  logic        dl_we;
  logic        fd_we;
  logic        set_we;
  logic [31:0] cb_rd;
  logic [31:0] dl_rd;
  logic [31:0] fd_rd;
  logic [31:0] wsel;
  logic [31:0] wnew;
  logic [11:0] next_tgt;
  logic [9:0]  dlv [3];
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b+:8] = n[8*b+:8];
      end
    end
    return r;
  endfunction
  function automatic logic [31:0] dim_cyc(input logic [3:0] c);
    return 32'(int'(lie_pkg::lie_dim_ms(c)) * CLK_KHZ);
  endfunction
  function automatic logic [31:0] tr_cyc(input logic [2:0] c);
    logic [31:0] v;
    v = 32'(int'(lie_pkg::lie_trans_ms(c)) * CLK_KHZ / int'(lie_pkg::TR_STEPS));
    return (v == 32'h0) ? 32'h1 : v;
  endfunction
  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  assign wr_go  = i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid;
  assign rd_go  = i_s_axi_arvalid && !o_s_axi_rvalid;
  assign o_s_axi_awready = wr_go;
  assign o_s_axi_wready  = wr_go;
  assign o_s_axi_arready = !o_s_axi_rvalid;
  assign cb_we  = wr_go && i_s_axi_awaddr[7:2] == lie_pkg::OFS_CB[7:2];
  assign dl_we  = wr_go && i_s_axi_awaddr[7:2] == lie_pkg::OFS_DL[7:2];
  assign fd_we  = wr_go && i_s_axi_awaddr[7:2] == lie_pkg::OFS_FD[7:2];
  assign set_we = wr_go && i_s_axi_awaddr[7:6] == lie_pkg::OFS_SET[7:6];
  assign cb_rd  = {20'h0, fen, trc, col, brt};
  assign dl_rd  = {8'h0, wl[2], wl[1], wl[0]};
  assign fd_rd  = {24'h0, dn, up};
  assign wsel = cb_we ? cb_rd : dl_we ? dl_rd : fd_we ? fd_rd : {8'h0, cset[i_s_axi_awaddr[5:2]]};
  assign wnew = merge(wsel, i_s_axi_wdata, i_s_axi_wstrb);
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= lie_pkg::RESP_OKAY;
    end else if (wr_go) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp  <= (cb_we || dl_we || fd_we || set_we) ? lie_pkg::RESP_OKAY : lie_pkg::RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h0;
      o_s_axi_rresp  <= lie_pkg::RESP_OKAY;
    end else if (rd_go) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp  <= lie_pkg::RESP_OKAY;
      if (i_s_axi_araddr[7:6] == lie_pkg::OFS_SET[7:6]) begin
        o_s_axi_rdata <= {8'h0, cset[i_s_axi_araddr[5:2]]};
      end else begin
        unique case (i_s_axi_araddr[7:2])
          lie_pkg::OFS_CB[7:2]: o_s_axi_rdata <= cb_rd;
          lie_pkg::OFS_DL[7:2]: o_s_axi_rdata <= dl_rd;
          lie_pkg::OFS_FD[7:2]: o_s_axi_rdata <= fd_rd;
          lie_pkg::OFS_ST[7:2]: o_s_axi_rdata <= {14'h0, tbusy, fad, 4'h0, cur};
          default: begin
            o_s_axi_rdata <= 32'h0;
            o_s_axi_rresp <= lie_pkg::RESP_SLVERR;
          end
        endcase
      end
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Frames and stored colour sets
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      brt <= lie_pkg::RST_BRT;
      col <= lie_pkg::RST_COL;
      trc <= lie_pkg::RST_TR;
      fen <= 1'b0;
      up  <= lie_pkg::RST_UP;
      dn  <= lie_pkg::RST_DN;
      for (int i = 0; i < 16; i++) begin
        cset[i] <= 24'h0;
      end
      for (int i = 0; i < 3; i++) begin
        wl[i] <= 8'h0;
      end
    end else begin
      if (cb_we) begin
        brt <= wnew[lie_pkg::CB_BRT+:4];
        col <= wnew[lie_pkg::CB_COL+:4];
        trc <= wnew[lie_pkg::CB_TR+:3];
        fen <= wnew[lie_pkg::CB_FEN];
        for (int i = 0; i < 3; i++) begin
          wl[i] <= cset[wnew[lie_pkg::CB_COL+:4]][8*i+:8];
        end
      end
      if (dl_we) begin
        for (int i = 0; i < 3; i++) begin
          wl[i] <= wnew[8*i+:8];
        end
      end
      if (fd_we) begin
        up <= wnew[lie_pkg::FD_UP+:4];
        dn <= wnew[lie_pkg::FD_DN+:4];
      end
      if (set_we) begin
        cset[i_s_axi_awaddr[5:2]] <= wnew[23:0];
      end
    end
  end

  // ----------------------------------------
  // Brightness fade
  // ----------------------------------------
  // The step accumulator adds the span each cycle, so every fade takes the
  // latched duration whatever its span, given at least 4095 cycles. Mid-fade writes restart from cur.
  assign next_tgt = lie_pkg::lie_brt_frac(wnew[lie_pkg::CB_BRT+:4]);
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cur  <= 12'h000;
      tgt  <= 12'h000;
      fad  <= 1'b0;
      facc <= 32'h0;
      fd   <= 12'h000;
      fdur <= 32'h1;
    end else if (cb_we) begin
      tgt  <= next_tgt;
      facc <= 32'h0;
      if (wnew[lie_pkg::CB_FEN]) begin
        fad  <= next_tgt != cur;
        fd   <= (next_tgt > cur) ? next_tgt - cur : cur - next_tgt;
        fdur <= (next_tgt > cur) ? dim_cyc(up) : dim_cyc(dn);
      end else begin
        cur <= next_tgt;
        fad <= 1'b0;
      end
    end else if (fad) begin
      if (cur == tgt) begin
        fad <= 1'b0;
      end else if (facc + 32'(fd) >= fdur) begin
        facc <= facc + 32'(fd) - fdur;
        cur  <= (tgt > cur) ? cur + 12'h001 : cur - 12'h001;
      end else begin
        facc <= facc + 32'(fd);
      end
    end
  end

  // ----------------------------------------
  // Colour transition timing
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      tload <= 1'b0;
      tbusy <= 1'b0;
      tmax  <= 10'h000;
      tcnt  <= 10'h000;
      tdiv  <= 32'h0;
      tcyc  <= 32'h1;
    end else if (tload) begin
      tload <= cb_we || dl_we;
      tmax  <= (dlv[0] > dlv[1]) ? ((dlv[0] > dlv[2]) ? dlv[0] : dlv[2])
                                 : ((dlv[1] > dlv[2]) ? dlv[1] : dlv[2]);
      tbusy <= dlv[0] != 10'h0 || dlv[1] != 10'h0 || dlv[2] != 10'h0;
      tcnt  <= 10'h000;
      tdiv  <= 32'h0;
      tcyc  <= tr_cyc(trc);
    end else begin
      tload <= cb_we || dl_we;
      if (tbusy) begin
        tdiv <= tick ? 32'h0 : tdiv + 32'h1;
        if (tick) begin
          tcnt  <= tcnt + 10'h001;
          tbusy <= tcnt + 10'h001 != tmax;
        end
      end
    end
  end
  assign tick = tbusy && !tload && tdiv == tcyc - 32'h1;
  // ----------------------------------------
  // Per-channel transition and pulse stream
  // ----------------------------------------
  for (genvar k = 0; k < 3; k++) begin : ch
    logic [9:0]  lvl;
    logic [9:0]  dst;
    logic [9:0]  dl;
    logic [9:0]  d;
    logic [10:0] acc;
    logic [21:0] prod;
    logic [22:0] pacc;
    logic [22:0] psum;
    assign dst  = {wl[k], 2'h0};
    assign dl   = (dst > lvl) ? dst - lvl : lvl - dst;
    assign dlv[k] = dl;
    assign prod = 22'(cur * lvl);
    assign psum = pacc + 23'(prod);
    always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
        lvl <= 10'h000;
        d   <= 10'h000;
        acc <= 11'h000;
      end else if (tload) begin
        d   <= dl;
        acc <= 11'h000;
      end else if (tick) begin
        if (acc + 11'(d) >= 11'(tmax)) begin
          acc <= acc + 11'(d) - 11'(tmax);
          lvl <= (dst > lvl) ? lvl + 10'h001 : lvl - 10'h001;
        end else begin
          acc <= acc + 11'(d);
        end
      end
    end
    // First-order modulation keeps the long-run duty exact at a high toggle rate.
    always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
        pacc   <= 23'h0;
        pwm[k] <= 1'b0;
      end else if (psum >= 23'(lie_pkg::PWM_FULL)) begin
        pacc   <= psum - 23'(lie_pkg::PWM_FULL);
        pwm[k] <= 1'b1;
      end else begin
        pacc   <= psum;
        pwm[k] <= 1'b0;
      end
    end
  end
  assign o_led_channel_a = pwm[0];
  assign o_led_channel_b = pwm[1];
  assign o_led_channel_c = pwm[2];
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_brt_reset: assert property (@(posedge i_ref_clk) $rose(i_rst_n) |-> brt == 4'h0 && cur == 12'h000)
    else $error("Brightness not zero after reset.");
  a_dur_reset: assert property (@(posedge i_ref_clk) $rose(i_rst_n) |-> up == 4'h3 && dn == 4'h8)
    else $error("Fade durations not default after reset.");
  a_off_dark: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cur == 12'h000 |=> pwm == 3'h0)
    else $error("Output on at zero brightness.");
  a_full_on: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ch[0].prod == lie_pkg::PWM_FULL |=> pwm[0])
    else $error("Full level not continuously on.");
  a_no_ramp: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cb_we && !wnew[lie_pkg::CB_FEN] |=> cur == tgt && !fad)
    else $error("Brightness not applied at once.");
  a_fade_step: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    fad && !cb_we |=> cur == $past(cur) || cur == $past(cur) + 12'h001 || cur == $past(cur) - 12'h001)
    else $error("Fade step larger than one.");
  a_dur_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    fad && fd_we && !cb_we |=> $stable(fdur))
    else $error("Running fade took new duration.");
  a_colour_copy: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cb_we && !set_we |=> wl[1] == cset[col][15:8])
    else $error("Colour set not copied.");
  a_trans_end: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !tbusy && !tload |-> ch[0].lvl == ch[0].dst && ch[1].lvl == ch[1].dst && ch[2].lvl == ch[2].dst)
    else $error("Transition ended with channels apart.");
endmodule
`default_nettype wire

// ### src/lie_pkg.sv
// Purpose: Constants, register map and decode tables of the LED intensity engine.
// Assumes: One 100 MHz clock; AXI4-Lite register access with 32-bit data.
// Notes:   Durations are kept in milliseconds and scaled to cycles in the engine.
`default_nettype none
package lie_pkg;
  // ----------------------------------------
  // Clock and widths
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int CLK_KHZ       = 1000000000 / CLK_PERIOD_PS;
  localparam logic [21:0] PWM_FULL = 22'h3FBC04;
  localparam logic [9:0]  TR_STEPS = 10'h3FC;
  // ----------------------------------------
  // Register offsets and fields
  // ----------------------------------------
  localparam logic [7:0] OFS_CB  = 8'h00;
  localparam logic [7:0] OFS_DL  = 8'h04;
  localparam logic [7:0] OFS_FD  = 8'h08;
  localparam logic [7:0] OFS_ST  = 8'h0C;
  localparam logic [7:0] OFS_SET = 8'h40;
  localparam int CB_BRT = 0;
  localparam int CB_COL = 4;
  localparam int CB_TR  = 8;
  localparam int CB_FEN = 11;
  localparam int FD_UP  = 0;
  localparam int FD_DN  = 4;
  localparam int ST_FAD = 16;
  localparam int ST_TRB = 17;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] RST_BRT = 4'h0;
  localparam logic [3:0] RST_COL = 4'h0;
  localparam logic [3:0] RST_UP  = 4'h3;
  localparam logic [3:0] RST_DN  = 4'h8;
  localparam logic [2:0] RST_TR  = 3'h3;
  // ----------------------------------------
  // Decode tables
  // ----------------------------------------
  function automatic logic [11:0] lie_brt_frac(input logic [3:0] c);
    case (c)
      4'h0: lie_brt_frac = 12'h000;
      4'h1: lie_brt_frac = 12'h040;
      4'h2: lie_brt_frac = 12'h060;
      4'h3: lie_brt_frac = 12'h080;
      4'h4: lie_brt_frac = 12'h0C0;
      4'h5: lie_brt_frac = 12'h100;
      4'h6: lie_brt_frac = 12'h180;
      4'h7: lie_brt_frac = 12'h200;
      4'h8: lie_brt_frac = 12'h300;
      4'h9: lie_brt_frac = 12'h400;
      4'hA: lie_brt_frac = 12'h600;
      4'hB: lie_brt_frac = 12'h800;
      4'hC: lie_brt_frac = 12'hC00;
      default: lie_brt_frac = 12'hFFF;
    endcase
  endfunction
  function automatic logic [15:0] lie_dim_ms(input logic [3:0] c);
    case (c)
      4'h0: lie_dim_ms = 16'h0118;
      4'h1: lie_dim_ms = 16'h01AE;
      4'h2: lie_dim_ms = 16'h023A;
      4'h3: lie_dim_ms = 16'h02C6;
      4'h4: lie_dim_ms = 16'h0352;
      4'h5: lie_dim_ms = 16'h03E8;
      4'h6: lie_dim_ms = 16'h0500;
      4'h7: lie_dim_ms = 16'h0596;
      4'h8: lie_dim_ms = 16'h06AE;
      4'h9: lie_dim_ms = 16'h073A;
      4'hA: lie_dim_ms = 16'h07D0;
      4'hB: lie_dim_ms = 16'h08E8;
      4'hC: lie_dim_ms = 16'h0A00;
      4'hD: lie_dim_ms = 16'h0BB8;
      4'hE: lie_dim_ms = 16'h0DE8;
      default: lie_dim_ms = 16'h11D0;
    endcase
  endfunction
  function automatic logic [15:0] lie_trans_ms(input logic [2:0] c);
    case (c)
      3'h0: lie_trans_ms = 16'h0032;
      3'h1: lie_trans_ms = 16'h0050;
      3'h2: lie_trans_ms = 16'h0082;
      3'h3: lie_trans_ms = 16'h00D2;
      3'h4: lie_trans_ms = 16'h0154;
      3'h5: lie_trans_ms = 16'h0226;
      3'h6: lie_trans_ms = 16'h037A;
      default: lie_trans_ms = 16'h05AA;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### verif/lie_stage_model.sv
// Purpose: Power stage stand-in that counts on-cycles of each LED channel.
// Assumes: Pulse streams are sampled on the rising clock edge.
// Notes:   Counts restart while i_clear is high.
`default_nettype none
module lie_stage_model (
  // Clock and control
  input  wire logic        i_ref_clk,
  input  wire logic        i_clear,
  // Pulse streams
  input  wire logic [2:0]  i_on,
  // On-cycle counts
  output logic      [15:0] o_cnt [3]
);
  timeunit 1ns;
  timeprecision 1ns;
  // The stage only averages the current, so counting on-cycles is all it needs.
  always_ff @(posedge i_ref_clk) begin
    for (int k = 0; k < 3; k++) begin
      o_cnt[k] <= i_clear ? 16'h0000 : o_cnt[k] + {15'h0000, i_on[k]};
    end
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
// Purpose: Self-checking bench for the LED intensity engine.
// Assumes: A small CLK_KHZ so fades and transitions stay short.
// Notes:   Bus results are checked by a monitor against a queue of notes.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  // A fade moves one step a cycle at most, so the shortest fade must reach 4095 cycles.
  localparam int K  = 15;
  localparam int N  = 2040;
  localparam int P7 = 1450 * K / 1020;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} lie_note_type;
  logic         clk     = 1'b0;
  logic         rst_n   = 1'b0;
  logic [7:0]   awaddr  = 8'h00;
  logic [7:0]   araddr  = 8'h00;
  logic [31:0]  wdata   = 32'h0;
  logic         awvalid = 1'b0;
  logic         wvalid  = 1'b0;
  logic         bready  = 1'b0;
  logic         arvalid = 1'b0;
  logic         rready  = 1'b0;
  logic         clr     = 1'b1;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp;
  logic [31:0]  rdata, v;
  logic [2:0]   led;
  logic [15:0]  cnt [3];
  logic [23:0]  lv;
  logic [23:0]  sets [16];
  lie_note_type q [$];
  lie_note_type nt;
  int           mismatches  = 0;
  int           checks_done = 0;
  int           i;
  longint       t_take;
  int           brt [16] = '{0, 64, 96, 128, 192, 256, 384, 512, 768, 1024, 1536, 2048, 3072, 4095, 4095, 4095};

  lie_led_intensity_engine #(.CLK_KHZ(K)) i_dut (
    .i_ref_clk       (clk),
    .i_rst_n         (rst_n),
    .i_s_axi_awaddr  (awaddr),
    .i_s_axi_awprot  (3'h0),
    .i_s_axi_awvalid (awvalid),
    .o_s_axi_awready (awready),
    .i_s_axi_wdata   (wdata),
    .i_s_axi_wstrb   (4'hF),
    .i_s_axi_wvalid  (wvalid),
    .o_s_axi_wready  (wready),
    .o_s_axi_bresp   (bresp),
    .o_s_axi_bvalid  (bvalid),
    .i_s_axi_bready  (bready),
    .i_s_axi_araddr  (araddr),
    .i_s_axi_arprot  (3'h0),
    .i_s_axi_arvalid (arvalid),
    .o_s_axi_arready (arready),
    .o_s_axi_rdata   (rdata),
    .o_s_axi_rresp   (rresp),
    .o_s_axi_rvalid  (rvalid),
    .i_s_axi_rready  (rready),
    .o_led_channel_a (led[0]),
    .o_led_channel_b (led[1]),
    .o_led_channel_c (led[2])
  );
  lie_stage_model i_stage (
    .i_ref_clk (clk),
    .i_clear   (clr),
    .i_on      (led),
    .o_cnt     (cnt)
  );

  always #5 clk = ~clk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic await(input int w);
    int   n;
    logic s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      s = (w == 0) ? awready : (w == 1) ? bvalid : (w == 2) ? arready : rvalid;
    end while (s !== 1'b1 && n < 500);
    if (n >= 500) mismatches++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q.push_back('{32'h0, 32'h0, r});
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    await(0);
    check("wready", 32'(wready), 32'h1);
    t_take = $time;
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    await(1);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    q.push_back('{d, m, r});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    await(2);
    arvalid <= 1'b0;
    await(3);
    v = rdata;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Polls a status busy bit; the poll period limits the precision to a few cycles.
  task automatic dur(input int b, input int exp, input int tol);
    int n;
    int d;
    n = 0;
    do begin
      rd(8'h0C, 32'h0, 32'h0, 2'h0);
      n++;
    end while (v[b] === 1'b1 && n < 8000);
    d = int'(($time - t_take) / 10);
    check("duration", (d >= exp - tol && d <= exp + tol), 32'h1);
  endtask
  task automatic duty(input int b, input logic [23:0] l);
    longint e;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (N) @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      e = longint'(N) * b * l[8*k +: 8] / (4095 * 255);
      check("duty", (cnt[k] + 3 >= e && cnt[k] <= e + 3), 32'h1);
    end
  endtask
  function automatic int mx(input logic [23:0] a, input logic [23:0] b);
    int m;
    int d;
    m = 0;
    for (int k = 0; k < 3; k++) begin
      d = int'(a[8*k +: 8]) - int'(b[8*k +: 8]);
      if (d < 0) d = -d;
      if (d > m) m = d;
    end
    return m;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Monitor and sequence
  // ----------------------------------------
  always @(posedge clk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      if (q.size() == 0) begin
        check("note", 32'h1, 32'h0);
      end else begin
        nt = q.pop_front();
        if (rvalid) begin
          check("rdata", rdata & nt.m, nt.d);
          check("rresp", 32'(rresp), 32'(nt.r));
        end else begin
          check("bresp", 32'(bresp), 32'(nt.r));
        end
      end
    end
  end
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    final_report();
  end
  initial begin
    void'($urandom(77977));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h0C, 32'h0, 32'hFFFFFFFF, 2'h0);
    rd(8'h08, 32'h83, 32'hFF, 2'h0);
    rd(8'h00, 32'h300, 32'hFFF, 2'h0);
    duty(brt[0], 24'hFFFFFF);
    wr(8'h10, 32'h1, 2'h2);
    rd(8'h10, 32'h0, 32'hFFFFFFFF, 2'h2);
    wr(8'h0C, 32'h1, 2'h2);
    $display("test reset and map done");
    for (i = 0; i < 16; i++) begin
      sets[i] = 24'($urandom);
      wr(8'h40 + 8'(4 * i), {8'h00, sets[i]}, 2'h0);
    end
    for (i = 0; i < 16; i++) rd(8'h40 + 8'(4 * i), {8'h00, sets[i]}, 32'hFFFFFF, 2'h0);
    wr(8'h00, 32'h05F, 2'h0);
    dur(17, 4 * mx(24'h0, sets[5]), 8);
    duty(4095, sets[5]);
    $display("test colour select done");
    for (i = 0; i < 16; i++) begin
      wr(8'h00, 32'h050 | 32'(i), 2'h0);
      rd(8'h0C, 32'(brt[i]), 32'hFFF, 2'h0);
    end
    wr(8'h00, 32'h05B, 2'h0);
    duty(brt[11], sets[5]);
    $display("test brightness done");
    wr(8'h00, 32'h75F, 2'h0);
    lv = 24'($urandom);
    wr(8'h04, {8'h00, lv}, 2'h0);
    dur(17, P7 * 4 * mx(lv, sets[5]), 8);
    duty(4095, lv);
    wr(8'h00, 32'h05F, 2'h0);
    dur(17, 4 * mx(lv, sets[5]), 8);
    wr(8'h04, 32'h00FFFFFF, 2'h0);
    dur(17, 4 * mx(sets[5], 24'hFFFFFF), 8);
    duty(4095, 24'hFFFFFF);
    $display("test transitions done");
    wr(8'h00, 32'h050, 2'h0);
    wr(8'h00, 32'h850, 2'h0);
    wr(8'h00, 32'h85F, 2'h0);
    dur(16, 710 * K, 12);
    rd(8'h0C, 32'hFFF, 32'hFFF, 2'h0);
    wr(8'h08, 32'h10, 2'h0);
    rd(8'h08, 32'h10, 32'hFF, 2'h0);
    wr(8'h00, 32'h850, 2'h0);
    dur(16, 430 * K, 12);
    rd(8'h0C, 32'h0, 32'hFFF, 2'h0);
    wr(8'h00, 32'h85F, 2'h0);
    dur(16, 280 * K, 12);
    wr(8'h00, 32'h850, 2'h0);
    dur(16, 430 * K, 12);
    wr(8'h00, 32'h050, 2'h0);
    $display("test fades done");
    final_report();
  end
endmodule
`default_nettype wire
